// ==== shared/ram_playback_defines.vh ====
// Constants for the waveform RAM playback sequencer and its register slave.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef RAM_PLAYBACK_DEFINES_VH
`define RAM_PLAYBACK_DEFINES_VH

// ----------
// Register byte offsets
// ----------
`define OFS_CTRL         4'h0
`define OFS_SEG0_BOUNDS  4'h4
`define OFS_SEG0_RATE    4'h8
`define OFS_SEG1_BOUNDS  4'hC
`define OFS_SEG1_RATE    5'h10
`define OFS_STATUS       5'h14

// ----------
// Control register fields
// ----------
`define CTRL_EN_BIT      0
`define CTRL_DEST_BIT    1
`define CTRL_OPM_LSB     2
`define CTRL_OPM_MSB     3
`define CTRL_RATE_LSB    8
`define CTRL_RATE_MSB    13
`define CTRL_RST_VAL     32'h0000_0100

// ----------
// Device operating modes
// ----------
`define OPM_SINGLE_TONE  2'h0
`define OPM_QUAD_UPCONV  2'h1
`define OPM_INTERP_DAC   2'h2

// ----------
// Segment bounds register fields
// ----------
`define SEG_START_LSB    0
`define SEG_START_MSB    9
`define SEG_END_LSB      16
`define SEG_END_MSB      25
`define SEG_MODE_LSB     28
`define SEG_MODE_MSB     30
`define SEG_RST_VAL      32'h0000_0000
`define RATE_RST_VAL     32'h0000_0001
`define SEG_MASK         32'h73FF_03FF
`define RATE_MASK        32'h0000_FFFF

// ----------
// Playback mode codes
// ----------
`define PBM_RAMP_UP      3'h1
`define PBM_BIDIR        3'h2
`define PBM_CONT_BIDIR   3'h3
`define PBM_RECIRC       3'h4

// ----------
// Status register fields and bus responses
// ----------
`define STAT_STATE_LSB   12
`define STAT_SEG_BIT     16
`define STAT_UP_BIT      17
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ----------
// Timer multiplier
// ----------
`define TIMER_MULT       2'h2

`endif

// ==== logic/step_timer.v ====
// Playback step timer: one tick per programmed period of clock cycles.
// Assumes a period of at least one; a restart pulse begins a fresh period.
module step_timer #(
  parameter PW = 24
) (
  // Clock, reset and enable
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          ce_i,
  // Control
  input  wire          run_i,
  input  wire          restart_i,
  input  wire [PW-1:0] period_i,
  // Expiry
  output reg           tick_o
);

  reg [PW-1:0] cnt_ff;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= {PW{1'b0}};
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (restart_i || !run_i) begin
        cnt_ff <= {PW{1'b0}};
        tick_o <= 1'b0;
      end else if (cnt_ff + {{(PW-1){1'b0}}, 1'b1} >= period_i) begin
        cnt_ff <= {PW{1'b0}};
        tick_o <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + {{(PW-1){1'b0}}, 1'b1};
        tick_o <= 1'b0;
      end
    end
  end

endmodule

// ==== logic/ram_playback_sequencer.v ====
// Address sequencer for a 1024-word waveform RAM with an AXI4-Lite register slave.
// Assumes trigger pin and update strobe are synchronous to clk_i.
//
// What this block does
// - Decode 3-bit mode: ramp, bidir, continuous, recirculate.
// - Play only in upconvert or interpolating converter mode.
// - Mode comes from the active segment register.
// - Continuous modes refused when feeding scaling multipliers.
// - Ramp-up: strobe or edge loads segment start.
// - Ramp-up counts up to end, then holds.
// - Address moves by one per timer expiry, except that recirculate jumps from end back to start.
// - Bidirectional: strobe only arms segment 0.
// - Rising edge: segment 0 start, count up.
// - Falling edge: segment 1 end, count down.
// - Early pin change restarts timer, reverses direction.
// - Continuous bidirectional reverses at each terminal address.
// - Continuous bidirectional: edge restarts from new segment.
// - Continuous bidirectional runs until strobe or edge.
// - Recirculate: after end, reload start and continue.
// - Recirculate repeats until strobe or edge restarts.
// - Rising edge selects segment 0, falling segment 1.
// - Segment: 10-bit start, end, 16-bit rate, 3-bit mode.
// - Multiplier timer period is four times R times M.
`include "ram_playback_defines.vh"

module ram_playback_sequencer #(
  parameter AW = 10,
  parameter RW = 16,
  parameter FW = 6
) (
  // Clock, reset and enable
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          ce_i,
  // AXI4-Lite write channels
  input  wire [4:0]    s_axi_awaddr_i,
  input  wire          s_axi_awvalid_i,
  output reg           s_axi_awready_o,
  input  wire [31:0]   s_axi_wdata_i,
  input  wire [3:0]    s_axi_wstrb_i,
  input  wire          s_axi_wvalid_i,
  output reg           s_axi_wready_o,
  output reg  [1:0]    s_axi_bresp_o,
  output reg           s_axi_bvalid_o,
  input  wire          s_axi_bready_i,
  // AXI4-Lite read channels
  input  wire [4:0]    s_axi_araddr_i,
  input  wire          s_axi_arvalid_i,
  output reg           s_axi_arready_o,
  output reg  [31:0]   s_axi_rdata_o,
  output reg  [1:0]    s_axi_rresp_o,
  output reg           s_axi_rvalid_o,
  input  wire          s_axi_rready_i,
  // Controller pins
  input  wire          playback_trigger_pin_i,
  input  wire          update_strobe_i,
  // RAM read port
  output reg  [AW-1:0] ram_addr_o,
  output reg           ram_word_valid_o
);

  localparam PW = 2 + FW + RW;
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  localparam [1:0] ST_HOLD  = 2'h3;

  // ----------------------------------------------------------------------
  // Register file: written copies and the copies the sequencer uses
  // ----------------------------------------------------------------------
  reg  [31:0] ctrl_ff, seg0_ff, rate0_ff, seg1_ff, rate1_ff;
  reg  [31:0] act_ctrl_ff, act_seg0_ff, act_rate0_ff, act_seg1_ff, act_rate1_ff;
  reg  [4:0]  aw_addr_ff;
  reg         aw_full_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         w_full_ff;
  reg  [1:0]  state_ff;
  reg  [AW-1:0] addr_ff;
  reg         seg_sel_ff;
  reg         up_ff;
  reg         trig_d_ff;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take  = s_axi_wvalid_i && s_axi_wready_o;
  wire do_write = aw_full_ff && w_full_ff && !s_axi_bvalid_o;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_addr_ff      <= 5'h00;
      aw_full_ff      <= 1'b0;
      w_data_ff       <= 32'h0000_0000;
      w_strb_ff       <= 4'h0;
      w_full_ff       <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `RESP_OKAY;
      ctrl_ff         <= `CTRL_RST_VAL;
      seg0_ff         <= `SEG_RST_VAL;
      seg1_ff         <= `SEG_RST_VAL;
      rate0_ff        <= `RATE_RST_VAL;
      rate1_ff        <= `RATE_RST_VAL;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr_i;
        aw_full_ff <= 1'b1;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata_i;
        w_strb_ff <= s_axi_wstrb_i;
        w_full_ff <= 1'b1;
      end
      s_axi_awready_o <= !aw_full_ff && !aw_take;
      s_axi_wready_o  <= !w_full_ff && !w_take;
      if (do_write) begin
        aw_full_ff     <= 1'b0;
        w_full_ff      <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= `RESP_OKAY;
        if (aw_addr_ff[4:2] == `OFS_CTRL >> 2) begin
          ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff);
        end else if (aw_addr_ff[4:2] == `OFS_SEG0_BOUNDS >> 2) begin
          seg0_ff <= merge(seg0_ff, w_data_ff, w_strb_ff) & `SEG_MASK;
        end else if (aw_addr_ff[4:2] == `OFS_SEG0_RATE >> 2) begin
          rate0_ff <= merge(rate0_ff, w_data_ff, w_strb_ff) & `RATE_MASK;
        end else if (aw_addr_ff[4:2] == `OFS_SEG1_BOUNDS >> 2) begin
          seg1_ff <= merge(seg1_ff, w_data_ff, w_strb_ff) & `SEG_MASK;
        end else if (aw_addr_ff[4:2] == `OFS_SEG1_RATE >> 2) begin
          rate1_ff <= merge(rate1_ff, w_data_ff, w_strb_ff) & `RATE_MASK;
        end else if (aw_addr_ff[4:2] != `OFS_STATUS >> 2) begin
          s_axi_bresp_o <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  wire [31:0] status_word = {14'h0000, up_ff, seg_sel_ff, 2'h0, state_ff,
                             {(12-AW){1'b0}}, addr_ff};

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= `RESP_OKAY;
        if (s_axi_araddr_i[4:2] == `OFS_CTRL >> 2) begin
          s_axi_rdata_o <= ctrl_ff;
        end else if (s_axi_araddr_i[4:2] == `OFS_SEG0_BOUNDS >> 2) begin
          s_axi_rdata_o <= seg0_ff;
        end else if (s_axi_araddr_i[4:2] == `OFS_SEG0_RATE >> 2) begin
          s_axi_rdata_o <= rate0_ff;
        end else if (s_axi_araddr_i[4:2] == `OFS_SEG1_BOUNDS >> 2) begin
          s_axi_rdata_o <= seg1_ff;
        end else if (s_axi_araddr_i[4:2] == `OFS_SEG1_RATE >> 2) begin
          s_axi_rdata_o <= rate1_ff;
        end else if (s_axi_araddr_i[4:2] == `OFS_STATUS >> 2) begin
          s_axi_rdata_o <= status_word;
        end else begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Update strobe moves written settings into the working copies
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_ctrl_ff  <= `CTRL_RST_VAL;
      act_seg0_ff  <= `SEG_RST_VAL;
      act_seg1_ff  <= `SEG_RST_VAL;
      act_rate0_ff <= `RATE_RST_VAL;
      act_rate1_ff <= `RATE_RST_VAL;
    end else if (ce_i && update_strobe_i) begin
      act_ctrl_ff  <= ctrl_ff;
      act_seg0_ff  <= seg0_ff;
      act_seg1_ff  <= seg1_ff;
      act_rate0_ff <= rate0_ff;
      act_rate1_ff <= rate1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Segment selection and mode checks
  // ----------------------------------------------------------------------
  wire [1:0] opm = act_ctrl_ff[`CTRL_OPM_MSB:`CTRL_OPM_LSB];
  wire to_mult  = act_ctrl_ff[`CTRL_DEST_BIT];
  wire play_ok  = act_ctrl_ff[`CTRL_EN_BIT] &&
                  (opm == `OPM_QUAD_UPCONV || opm == `OPM_INTERP_DAC);
  wire rise     = playback_trigger_pin_i && !trig_d_ff;
  wire fall     = !playback_trigger_pin_i && trig_d_ff;
  wire edge_any = rise || fall;

  // Fields of the running segment and of the segment a new event picks.
  wire [31:0]   cur_seg   = seg_sel_ff ? act_seg1_ff : act_seg0_ff;
  wire [AW-1:0] cur_start = cur_seg[`SEG_START_MSB:`SEG_START_LSB];
  wire [AW-1:0] cur_end   = cur_seg[`SEG_END_MSB:`SEG_END_LSB];
  wire [2:0]    cur_mode  = cur_seg[`SEG_MODE_MSB:`SEG_MODE_LSB];
  wire [RW-1:0] cur_rate  = seg_sel_ff ? act_rate1_ff[RW-1:0] : act_rate0_ff[RW-1:0];

  wire          new_sel   = edge_any ? fall : seg_sel_ff;
  wire [31:0]   new_seg   = new_sel ? act_seg1_ff : act_seg0_ff;
  wire [2:0]    new_mode  = new_seg[`SEG_MODE_MSB:`SEG_MODE_LSB];

  function mode_ok;
    input [2:0] m;
    input       mult;
    begin
      mode_ok = (m == `PBM_RAMP_UP) || (m == `PBM_BIDIR) ||
                (!mult && (m == `PBM_CONT_BIDIR || m == `PBM_RECIRC));
    end
  endfunction

  // ----------------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------------
  wire [FW-1:0] rate_fac = act_ctrl_ff[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
  wire [PW-1:0] rm_prod  = {{(PW-FW){1'b0}}, rate_fac} * {{(PW-RW){1'b0}}, cur_rate};
  wire [PW-1:0] mult_per = rm_prod << `TIMER_MULT;
  wire [PW-1:0] period   = to_mult ? mult_per : {{(PW-1){1'b0}}, 1'b1};
  wire          start_evt = play_ok && (edge_any || update_strobe_i);
  wire          tick;

  step_timer #(.PW(PW)) u_timer (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .run_i     (state_ff == ST_RUN),
    .restart_i (start_evt),
    .period_i  (period),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------------
  // Address state machine
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff         <= ST_IDLE;
      addr_ff          <= {AW{1'b0}};
      seg_sel_ff       <= 1'b0;
      up_ff            <= 1'b1;
      trig_d_ff        <= 1'b0;
      ram_addr_o       <= {AW{1'b0}};
      ram_word_valid_o <= 1'b0;
    end else if (ce_i) begin
      trig_d_ff        <= playback_trigger_pin_i;
      ram_word_valid_o <= tick && state_ff == ST_RUN;
      ram_addr_o       <= addr_ff;
      if (!play_ok) begin
        state_ff <= ST_IDLE;
      end else if (start_evt) begin
        seg_sel_ff <= new_sel;
        if (!mode_ok(new_mode, to_mult)) begin
          state_ff <= ST_IDLE;
        end else if (new_mode == `PBM_BIDIR && !edge_any) begin
          seg_sel_ff <= 1'b0;
          state_ff   <= ST_ARMED;
        end else if (new_mode == `PBM_BIDIR && fall) begin
          addr_ff  <= new_seg[`SEG_END_MSB:`SEG_END_LSB];
          up_ff    <= 1'b0;
          state_ff <= ST_RUN;
        end else begin
          addr_ff  <= new_seg[`SEG_START_MSB:`SEG_START_LSB];
          up_ff    <= 1'b1;
          state_ff <= ST_RUN;
        end
      end else if (state_ff == ST_RUN && tick) begin
        case (cur_mode)
          `PBM_RAMP_UP: begin
            if (addr_ff == cur_end) begin
              state_ff <= ST_HOLD;
            end else begin
              addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
          end
          `PBM_BIDIR: begin
            if ((up_ff && addr_ff == cur_end) || (!up_ff && addr_ff == cur_start)) begin
              state_ff <= ST_HOLD;
            end else if (up_ff) begin
              addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
            end else begin
              addr_ff <= addr_ff - {{(AW-1){1'b0}}, 1'b1};
            end
          end
          `PBM_CONT_BIDIR: begin
            if (up_ff && addr_ff == cur_end) begin
              up_ff   <= 1'b0;
              addr_ff <= addr_ff - {{(AW-1){1'b0}}, 1'b1};
            end else if (!up_ff && addr_ff == cur_start) begin
              up_ff   <= 1'b1;
              addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
            end else if (up_ff) begin
              addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
            end else begin
              addr_ff <= addr_ff - {{(AW-1){1'b0}}, 1'b1};
            end
          end
          `PBM_RECIRC: begin
            if (addr_ff == cur_end) begin
              addr_ff <= cur_start;
            end else begin
              addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ==== sim/rps_checker_asserts.sv ====
// Concurrent checks on the playback sequencer ports and its register slave.
// Assumes it is bound to the sequencer and sees only that module's ports.
`include "ram_playback_defines.vh"

module rps_checker #(
  parameter AW = 10
) (
  // Clock and reset
  input logic          clk_i,
  input logic          rst_n_i,
  // Register bus
  input logic [4:0]    s_axi_awaddr_i,
  input logic          s_axi_awvalid_i,
  input logic          s_axi_awready_o,
  input logic          s_axi_wvalid_i,
  input logic          s_axi_wready_o,
  input logic [1:0]    s_axi_bresp_o,
  input logic          s_axi_bvalid_o,
  input logic          s_axi_bready_i,
  input logic [4:0]    s_axi_araddr_i,
  input logic          s_axi_arvalid_i,
  input logic          s_axi_arready_o,
  input logic [31:0]   s_axi_rdata_o,
  input logic [1:0]    s_axi_rresp_o,
  input logic          s_axi_rvalid_o,
  input logic          s_axi_rready_i,
  // Controller pins and RAM port
  input logic          playback_trigger_pin_i,
  input logic          update_strobe_i,
  input logic [AW-1:0] ram_addr_o,
  input logic          ram_word_valid_o
);
  logic       pin_ff;
  logic [3:0] ev_ff;
  logic       seen_ff;
  logic       ev;

  assign ev = update_strobe_i | (playback_trigger_pin_i ^ pin_ff);

  // Recent start events, so that an address move can be traced to a cause.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_ff  <= 1'b0;
      ev_ff   <= 4'h0;
      seen_ff <= 1'b0;
    end else begin
      pin_ff  <= playback_trigger_pin_i;
      ev_ff   <= {ev_ff[2:0], ev};
      seen_ff <= seen_ff | ev;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence aw_w_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence ar_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  write_resp_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("Write response missing");
  bad_write_a: assert property (aw_w_taken ##0 (s_axi_awaddr_i > 5'h14)
    |-> ##[1:2] (s_axi_bvalid_o && s_axi_bresp_o == `RESP_SLVERR))
    else $error("Unmapped write not refused");
  read_resp_a: assert property (ar_taken |=> s_axi_rvalid_o)
    else $error("Read data late");
  bad_read_a: assert property (ar_taken ##0 (s_axi_araddr_i > 5'h14)
    |=> s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("Unmapped read not refused");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("Write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("Read data dropped");
  aw_busy_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("Address ready while one is held");
  ar_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("Read address ready while data pending");
  addr_cause_a: assert property (
    $changed(ram_addr_o) |-> $past(ram_word_valid_o) || ev_ff != 4'h0)
    else $error("RAM address moved without expiry or start event");
  idle_reset_a: assert property (!seen_ff |-> !ram_word_valid_o)
    else $error("Word valid before any start event");
endmodule

bind ram_playback_sequencer rps_checker #(.AW(AW)) chk (
  .clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .playback_trigger_pin_i, .update_strobe_i,
  .ram_addr_o, .ram_word_valid_o
);

// ==== sim/ctrl_partner.sv ====
// External controller model: drives the trigger pin and the update strobe.
// Assumes one caller at a time; segment one data, read downward, is
// expected in reverse order, and this model holds no RAM image.
module ctrl_partner (
  // Clock
  input  logic clk_i,
  // Controller pins
  output logic trig_o,
  output logic strobe_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    trig_o   = 1'b0;
    strobe_o = 1'b0;
  end

  task automatic pulse_strobe();
    @(posedge clk_i);
    strobe_o <= 1'b1;
    @(posedge clk_i);
    strobe_o <= 1'b0;
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk_i);
    trig_o <= v;
  endtask
endmodule

// ==== sim/ram_playback_sequencer_tb.sv ====
// Self-checking bench for the waveform RAM playback sequencer.
// Assumes the partner model drives the trigger pin and the update strobe.
`include "ram_playback_defines.vh"

module ram_playback_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  awaddr  = 5'h00;
  logic [4:0]  araddr  = 5'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        ce      = 1'b1;
  logic [3:0]  wstrb   = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, trig, strobe, pvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [9:0]  paddr;
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          seed       = 74408;
  int          obs[$];
  int          tq[$];

  always #25 clk_i = ~clk_i;

  ram_playback_sequencer uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .playback_trigger_pin_i(trig), .update_strobe_i(strobe),
    .ram_addr_o(paddr), .ram_word_valid_o(pvalid)
  );

  ctrl_partner partner (.clk_i(clk_i), .trig_o(trig), .strobe_o(strobe));

  always @(posedge clk_i) begin
    cyc++;
    if (pvalid === 1'b1) begin
      obs.push_back(paddr);
      tq.push_back(cyc);
    end
  end

  // ----------
  // Bus tasks, reference model and comparison
  // ----------
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (bvalid === 1'b1 && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
      if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
      if ($random(seed) % 2 == 0) bready <= 1'b1;
    end
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (rvalid === 1'b1 && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
      if ($random(seed) % 2 == 0) rready <= 1'b1;
    end
  endtask

  function automatic logic [31:0] seg(input logic [2:0] m, input logic [9:0] s, input logic [9:0] e);
    return {1'b0, m, 2'b00, e, 6'h00, s};
  endfunction

  function automatic logic [31:0] ctl(input logic dst, input logic [1:0] opm, input logic [5:0] r);
    return {18'h0, r, 4'h0, opm, dst, 1'b1};
  endfunction

  // Kinds: 1 count up and hold, 2 count down and hold, 3 ping-pong, 4 wrap.
  function automatic void build(ref int q[$], input int k, input int s, input int e, input int n);
    int a;
    int d;
    a = (k == 2) ? e : s;
    d = (k == 2) ? -1 : 1;
    q.delete();
    repeat (n) begin
      q.push_back(a);
      if (k == 3 && (a + d > e || a + d < s)) d = -d;
      if (k == 4 && a == e) a = s;
      else a = a + d;
    end
  endfunction

  // Leading words left over from an aborted waveform are skipped.
  task automatic expect_run(input string what, input int k, s, e, n, input bit hold);
    int q[$];
    int sk;
    build(q, k, s, e, n);
    repeat (n + 10) @(posedge clk_i);
    sk = 0;
    while (sk < 5 && obs.size() > sk && obs[sk] != q[0]) sk++;
    for (int i = 0; i < n; i++) check_val(what, q[i], (sk + i < obs.size()) ? obs[sk + i] : -1);
    if (hold) begin
      repeat (10) @(posedge clk_i);
      check_val({what, " count"}, sk + n, obs.size());
    end
    obs.delete();
  endtask

  // Writes all segment settings, then copies them with one strobe.
  task automatic cfg(input logic [31:0] c, s0, s1, input logic [15:0] m);
    logic [1:0] r;
    axi_write(`OFS_CTRL, c, r);
    axi_write(`OFS_SEG0_BOUNDS, s0, r);
    axi_write(`OFS_SEG0_RATE, {16'h0, m}, r);
    axi_write(`OFS_SEG1_BOUNDS, s1, r);
    axi_write(`OFS_SEG1_RATE, {16'h0, m}, r);
    partner.pulse_strobe();
    repeat (4) @(posedge clk_i);
    obs.delete();
    tq.delete();
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end

  // ----------
  // Main sequence
  // ----------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          s;
    int          e;
    logic [5:0]  bad[8] = '{6'h10, 6'h15, 6'h16, 6'h17, 6'h01, 6'h19, 6'h2B, 6'h2C};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    axi_read(`OFS_CTRL, d, r);
    check_val("ctrl", `CTRL_RST_VAL, d);
    axi_read(`OFS_SEG1_BOUNDS, d, r);
    check_val("seg1", `SEG_RST_VAL, d);
    axi_read(`OFS_SEG0_RATE, d, r);
    check_val("rate0", `RATE_RST_VAL, d);
    axi_read(5'h1C, d, r);
    check_val("unmapped read", `RESP_SLVERR, r);
    axi_write(5'h18, 32'h5, r);
    check_val("unmapped write", `RESP_SLVERR, r);
    axi_write(`OFS_SEG0_BOUNDS, 32'hFFFFFFFF, r);
    axi_read(`OFS_SEG0_BOUNDS, d, r);
    check_val("seg0 fields", 32'h73FF03FF, d);
    s = $random(seed);
    axi_write(`OFS_SEG1_RATE, s, r);
    axi_read(`OFS_SEG1_RATE, d, r);
    check_val("rate1", {16'h0, s[15:0]}, d);
    s = {$random(seed)} % 256 + 16;
    e = s + 5 + {$random(seed)} % 10;
    cfg(ctl(0, 1, 6'h01), seg(1, s, e), seg(1, 600, 620), 16'h1);
    partner.pulse_strobe();
    expect_run("ramp", 1, s, e, e - s + 1, 1);
    partner.set_pin(1'b1);
    expect_run("ramp rise", 1, s, e, e - s + 1, 1);
    partner.set_pin(1'b0);
    expect_run("ramp fall", 1, 600, 620, 21, 1);
    cfg(ctl(0, 1, 6'h01), seg(4, 40, 45), seg(4, 80, 84), 16'h1);
    partner.pulse_strobe();
    expect_run("wrap", 4, 80, 84, 15, 0);
    partner.set_pin(1'b1);
    expect_run("wrap abort", 4, 40, 45, 15, 0);
    cfg(ctl(0, 2, 6'h01), seg(3, 100, 104), seg(4, 200, 203), 16'h1);
    partner.pulse_strobe();
    expect_run("pingpong", 3, 100, 104, 14, 0);
    partner.set_pin(1'b0);
    expect_run("pingpong abort", 4, 200, 203, 10, 0);
    cfg(ctl(0, 1, 6'h01), seg(2, 300, 310), seg(2, 400, 410), 16'h1);
    partner.pulse_strobe();
    repeat (6) @(posedge clk_i);
    obs.delete();
    repeat (20) @(posedge clk_i);
    check_val("armed words", 0, obs.size());
    partner.set_pin(1'b1);
    expect_run("bidir up", 1, 300, 310, 11, 1);
    partner.set_pin(1'b0);
    expect_run("bidir down", 2, 400, 410, 11, 1);
    partner.set_pin(1'b1);
    repeat (4) @(posedge clk_i);
    obs.delete();
    partner.set_pin(1'b0);
    expect_run("bidir early", 2, 400, 410, 11, 1);
    cfg(ctl(1, 1, 6'h02), seg(1, 500, 504), seg(1, 510, 514), 16'h2);
    partner.pulse_strobe();
    repeat (120) @(posedge clk_i);
    check_val("slow words", 5, obs.size());
    check_val("slow last", 504, obs[4]);
    check_val("slow period", 16, tq[2] - tq[1]);
    foreach (bad[i]) begin
      cfg(ctl(bad[i][5], bad[i][4:3], 6'h01), seg(bad[i][2:0], 20, 30),
          seg(bad[i][2:0], 40, 50), 16'h1);
      partner.pulse_strobe();
      repeat (6) @(posedge clk_i);
      obs.delete();
      repeat (30) @(posedge clk_i);
      check_val("idle words", 0, obs.size());
    end
    end_of_test();
  end
endmodule
